// ==== src/bpd_cfg.svh ====
/*
 Constants of the bidirectional port: register addresses, widths, reset values and the bit mask.
 Assumes inclusion by its bare name; the guard makes repeated inclusion harmless.
*/
`ifndef BPD_CFG_SVH
`define BPD_CFG_SVH

// Width of the port latch, the direction register and the pin group.
`define BPD_WIDTH 8
// Width of the bit index of a single-bit set or clear.
`define BPD_BIT_W 3
// Width of the register-file address.
`define BPD_ADDR_W 8
// Address of the third_port_pins data register.
`define BPD_ADDR_PORT 8'h07
// Address of the third_port_direction register.
`define BPD_ADDR_DIR 8'h87
// Direction value after every reset: all pins high impedance.
`define BPD_DIR_RESET 8'hFF
// Read data value loaded by reset; an unmapped read uses BPD_UNMAPPED.
`define BPD_RDATA_RESET 8'h00
// Value read back from an unmapped address.
`define BPD_UNMAPPED 8'h00
// Mask of bit zero, shifted to select one bit.
`define BPD_BIT_ONE 8'h01

`endif

// ==== src/bpd_pkg.sv ====
/*
 Types of the bidirectional port: data word, operation codes and the register access request.
 Assumes the constants header is on the include path.
*/
`include "bpd_cfg.svh"

package bpd_pkg;

    typedef logic [`BPD_WIDTH-1:0] bpd_data_type;
    typedef logic [`BPD_ADDR_W-1:0] bpd_addr_type;
    typedef logic [`BPD_BIT_W-1:0] bpd_bit_type;

    // Operations of the register-file access path.
    typedef enum logic [2:0] {
        BPD_OP_NONE,
        BPD_OP_READ,
        BPD_OP_WRITE,
        BPD_OP_BIT_SET,
        BPD_OP_BIT_CLEAR
    } bpd_op_type;

    // One instruction-cycle access, held for exactly one clock.
    typedef struct packed {
        bpd_op_type op;
        bpd_addr_type addr;
        bpd_data_type data;
        bpd_bit_type bit_sel;
    } bpd_req_type;

endpackage

// ==== src/bpd_sync.sv ====
/*
 Two-stage synchroniser for the port pin inputs, one pair of flip-flops per pin.
 Assumes the pin levels are asynchronous to SYS_CLK and RESET is synchronous, active high.
*/
`timescale 1ns/1ps
`include "bpd_cfg.svh"

module bpd_sync
    import bpd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire bpd_data_type ASYNC_IN,
    output bpd_data_type SYNC_OUT
);

    genvar gi;

    generate
        for (gi = 0; gi < `BPD_WIDTH; gi = gi + 1) begin : g_bit
            logic stage1_reg;
            logic stage2_reg;
            // The first stage feeds only the second stage.
            always_ff @(posedge SYS_CLK) begin
                if (RESET) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= ASYNC_IN[gi];
                    stage2_reg <= stage1_reg;
                end
            end
            assign SYNC_OUT[gi] = stage2_reg;
        end
    endgenerate

endmodule

// ==== src/bpd_port.sv ====
/*
 Eight-pin bidirectional port with output latch and per-pin direction register.
 Assumes one SYS_CLK cycle per instruction cycle, requests held for one cycle, and a testbench that
 resolves each pin wire from PIN_OUT and PIN_OE.
*/
// Summary of operation
// - One eight-bit output latch, one bit per port pin.
// - Direction register bit n controls pin n independently.
// - Direction bit one puts that pin's driver in high impedance.
// - Direction bit zero drives the pin from its latch bit.
// - Port read returns pin levels; port write updates only the latch.
// - A full port write loads the request data; only bit set and clear are read-modify-write on the pin levels.
// - Port bit set or clear reads all pins, changes one bit, writes all back.
// - Writes commit at cycle end; reads return pin levels sampled two edges before cycle end, through the synchroniser.
// - Port latch is not reset; its content survives every reset.
// - Direction register becomes all ones on every reset.
// - All eight pins are bidirectional with a plain logic-level input.
`timescale 1ns/1ps
`include "bpd_cfg.svh"

module bpd_port
    import bpd_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire bpd_req_type REG_REQ,
    output bpd_data_type REG_RDATA,
    output logic REG_RDONE,
    output logic REG_MISS,
    input wire bpd_data_type PIN_IN,
    output bpd_data_type PIN_OUT,
    output bpd_data_type PIN_OE
);

    bpd_data_type pins_sync;
    bpd_data_type latch_reg;
    bpd_data_type latch_next;
    bpd_data_type dir_reg;
    bpd_data_type dir_next;
    bpd_data_type rdata_reg;
    bpd_data_type rdata_next;
    logic rdone_reg;
    logic rdone_next;
    logic miss_reg;
    logic miss_next;
    logic wrote_reg;
    logic wrote_next;
    // Counts edges since reset, so checks skip the synchroniser's cleared stages.
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic hit_port;
    logic hit_dir;
    logic is_read;
    logic is_modify;
    bpd_data_type bit_mask;

    // Applies a write, bit set or bit clear to the value that was read.
    function automatic bpd_data_type apply_op(input bpd_data_type base, input bpd_req_type req,
                                              input bpd_data_type mask);
        bpd_data_type result;
        result = base;
        if (req.op == BPD_OP_WRITE) begin
            result = req.data;
        end else if (req.op == BPD_OP_BIT_SET) begin
            result = base | mask;
        end else if (req.op == BPD_OP_BIT_CLEAR) begin
            result = base & ~mask;
        end
        return result;
    endfunction

    // Pin levels are synchronised before reads and read-modify-writes use them.
    bpd_sync u_sync (
        .SYS_CLK(SYS_CLK),
        .RESET(RESET),
        .ASYNC_IN(PIN_IN),
        .SYNC_OUT(pins_sync)
    );

    // Decodes the request and computes the next register values.
    always_comb begin
        hit_port = 1'b0;
        hit_dir = 1'b0;
        if (REG_REQ.addr == `BPD_ADDR_PORT) begin
            hit_port = 1'b1;
        end else if (REG_REQ.addr == `BPD_ADDR_DIR) begin
            hit_dir = 1'b1;
        end
        is_read = (REG_REQ.op == BPD_OP_READ);
        is_modify = (REG_REQ.op == BPD_OP_WRITE) || (REG_REQ.op == BPD_OP_BIT_SET) ||
                    (REG_REQ.op == BPD_OP_BIT_CLEAR);
        bit_mask = `BPD_BIT_ONE << REG_REQ.bit_sel;
        latch_next = latch_reg;
        dir_next = dir_reg;
        rdata_next = rdata_reg;
        rdone_next = is_read;
        miss_next = 1'b0;
        wrote_next = wrote_reg;
        settle_next = settle_reg;
        if (settle_reg != 2'h3) begin
            settle_next = settle_reg + 2'h1;
        end
        if (is_read || is_modify) begin
            if (hit_port) begin
                if (is_read) begin
                    // The pins are read, never the latch.
                    rdata_next = pins_sync;
                end else begin
                    // For bit set and clear the value modified is the pin levels, all eight of them; a write loads the request data.
                    latch_next = apply_op(pins_sync, REG_REQ, bit_mask);
                    wrote_next = 1'b1;
                end
            end else if (hit_dir) begin
                if (is_read) begin
                    rdata_next = dir_reg;
                end else begin
                    dir_next = apply_op(dir_reg, REG_REQ, bit_mask);
                end
            end else begin
                miss_next = 1'b1;
                if (is_read) begin
                    rdata_next = `BPD_UNMAPPED;
                end
            end
        end
    end

    // The latch has no reset, so it keeps its content across every reset.
    always_ff @(posedge SYS_CLK) begin
        latch_reg <= latch_next;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            dir_reg <= `BPD_DIR_RESET;
            rdata_reg <= `BPD_RDATA_RESET;
            rdone_reg <= 1'b0;
            miss_reg <= 1'b0;
            wrote_reg <= 1'b0;
            settle_reg <= 2'h0;
        end else begin
            dir_reg <= dir_next;
            rdata_reg <= rdata_next;
            rdone_reg <= rdone_next;
            miss_reg <= miss_next;
            wrote_reg <= wrote_next;
            settle_reg <= settle_next;
        end
    end

    genvar gp;

    // Each pin drives its latch bit while its direction bit is zero.
    generate
        for (gp = 0; gp < `BPD_WIDTH; gp = gp + 1) begin : g_pin
            assign PIN_OE[gp] = ~dir_reg[gp];
            assign PIN_OUT[gp] = latch_reg[gp] & ~dir_reg[gp];
        end
    endgenerate

    assign REG_RDATA = rdata_reg;
    assign REG_RDONE = rdone_reg;
    assign REG_MISS = miss_reg;

    // Checks of the port behaviour.
    a_dir_after_reset: assert property (
        @(posedge SYS_CLK) $fell(RESET) |-> (dir_reg == `BPD_DIR_RESET) && (PIN_OE == 8'h00)
    ) else $error("Direction register not all ones after reset.");

    a_hiz_no_drive: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_WRITE) && (REG_REQ.addr == `BPD_ADDR_DIR)
        |=> (PIN_OE == ~$past(REG_REQ.data)) && ((PIN_OUT & ~PIN_OE) == 8'h00)
    ) else $error("Pin with direction one is still driven.");

    a_drive_from_latch: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_WRITE) && (REG_REQ.addr == `BPD_ADDR_PORT)
        |=> PIN_OUT == ($past(REG_REQ.data) & PIN_OE)
    ) else $error("Driven pin does not show its latch bit.");

    a_port_read_pins: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_READ) && (REG_REQ.addr == `BPD_ADDR_PORT) && settle_reg[1]
        |=> REG_RDONE && (REG_RDATA == $past(PIN_IN, 3))
    ) else $error("Port read does not return synchronised pin levels.");

    a_read_no_latch: assert property (
        @(posedge SYS_CLK) disable iff (RESET || !wrote_reg)
        (REG_REQ.op == BPD_OP_READ) |=> $stable(latch_reg)
    ) else $error("A read changed the port latch.");

    a_write_commit: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_WRITE) && (REG_REQ.addr == `BPD_ADDR_PORT)
        |=> (latch_reg == $past(REG_REQ.data)) && $stable(dir_reg)
    ) else $error("Port write not committed at cycle end.");

    a_bit_set_rmw: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_BIT_SET) && (REG_REQ.addr == `BPD_ADDR_PORT)
        |=> latch_reg == ($past(pins_sync) | (`BPD_BIT_ONE << $past(REG_REQ.bit_sel)))
    ) else $error("Bit set did not write back the pin levels.");

    a_bit_clear_rmw: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_BIT_CLEAR) && (REG_REQ.addr == `BPD_ADDR_PORT)
        |=> latch_reg == ($past(pins_sync) & ~(`BPD_BIT_ONE << $past(REG_REQ.bit_sel)))
    ) else $error("Bit clear did not write back the pin levels.");

    a_dir_bit_ops: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_BIT_CLEAR) && (REG_REQ.addr == `BPD_ADDR_DIR)
        |=> dir_reg == ($past(dir_reg) & ~(`BPD_BIT_ONE << $past(REG_REQ.bit_sel)))
    ) else $error("Direction bit clear touched other bits.");

    a_latch_held: assert property (
        @(posedge SYS_CLK) disable iff (!wrote_reg)
        !((REG_REQ.op != BPD_OP_NONE) && (REG_REQ.op != BPD_OP_READ) && hit_port) |=> $stable(latch_reg)
    ) else $error("Port latch changed without a port write.");

    a_latch_over_reset: assert property (
        @(posedge SYS_CLK) wrote_reg && RESET |=> (latch_reg == $past(latch_reg))
    ) else $error("Port latch changed across a reset.");

    a_sync_delay: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        settle_reg[1] |-> pins_sync == $past(PIN_IN, 2)
    ) else $error("Pin levels not delayed by two stages.");

    a_unmapped_zero: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (REG_REQ.op == BPD_OP_READ) && !hit_port && !hit_dir
        |=> REG_MISS && REG_RDONE && (REG_RDATA == `BPD_UNMAPPED)
        ##1 (!REG_RDONE || $past(REG_REQ.op == BPD_OP_READ))
    ) else $error("Unmapped read not answered with zero.");

endmodule

// ==== bench/bpd_pin_model.sv ====
/*
 Model of the circuitry outside the port pins: one external driver per pin and pull-ups.
 Assumes the port's PIN_OUT and PIN_OE, and a bench that sets the external drive per pin.
*/
`timescale 1ns/1ps

module bpd_pin_model
    import bpd_pkg::*;
(
    input wire bpd_data_type PIN_OUT,
    input wire bpd_data_type PIN_OE,
    input wire bpd_data_type EXT_VAL,
    input wire bpd_data_type EXT_EN,
    output bpd_data_type PIN_LEVEL
);
    // Outside drivers yield where the port drives, so pins never fight; free pins rest high.
    always_comb begin
        for (int i = 0; i < $bits(bpd_data_type); i++) begin
            if (PIN_OE[i]) begin
                PIN_LEVEL[i] = PIN_OUT[i];
            end else if (EXT_EN[i]) begin
                PIN_LEVEL[i] = EXT_VAL[i];
            end else begin
                PIN_LEVEL[i] = 1'b1;
            end
        end
    end
endmodule

// ==== bench/test_bpd_port.sv ====
/*
 Self-checking testbench of the bidirectional port, with the pin circuitry model.
 Assumes bpd_port, bpd_pin_model and the package; inputs change at the falling clock edge.
*/
`timescale 1ns/1ps
`include "bpd_cfg.svh"

module test_bpd_port;
    import bpd_pkg::*;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    bpd_req_type reg_req = '{BPD_OP_NONE, 8'h00, 8'h00, 3'h0};
    bpd_data_type reg_rdata, pin_out, pin_oe, pin_level;
    bpd_data_type ext_val = 8'h00;
    bpd_data_type ext_en = 8'h00;
    logic reg_rdone, reg_miss;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    bpd_port DUT (.SYS_CLK(sys_clk), .RESET(reset), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
        .REG_RDONE(reg_rdone), .REG_MISS(reg_miss), .PIN_IN(pin_level), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe));
    bpd_pin_model partner (.PIN_OUT(pin_out), .PIN_OE(pin_oe), .EXT_VAL(ext_val), .EXT_EN(ext_en),
        .PIN_LEVEL(pin_level));

    always #5 sys_clk = ~sys_clk;

    // Cuts a hung run short well after the sequence should have ended.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Presents one access for one cycle; the caller releases the request or issues the next.
    task automatic access(input bpd_op_type op, input bpd_addr_type addr, input bpd_data_type data,
        input bpd_bit_type b);
        reg_req = '{op, addr, data, b};
        @(negedge sys_clk);
    endtask

    task automatic rel;
        reg_req = '{BPD_OP_NONE, 8'h00, 8'h00, 3'h0};
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic do_reset;
        reset = 1'b1;
        idle(2);
        reset = 1'b0;
    endtask

    task automatic test_reset_state;
        check(pin_oe, 8'h00);
        check(pin_out, 8'h00);
        access(BPD_OP_READ, `BPD_ADDR_DIR, 8'h00, 3'h0);
        rel();
        check(reg_rdata, `BPD_DIR_RESET);
        check({7'h00, reg_rdone}, 8'h01);
        idle(3);
    endtask

    task automatic test_drive_and_read;
        ext_en = 8'hF0;
        ext_val = 8'hA0;
        access(BPD_OP_WRITE, `BPD_ADDR_DIR, 8'hF0, 3'h0);
        access(BPD_OP_WRITE, `BPD_ADDR_PORT, 8'h5A, 3'h0);
        rel();
        check(pin_oe, 8'h0F);
        check(pin_out, 8'h0A);
        idle(3);
        access(BPD_OP_READ, `BPD_ADDR_PORT, 8'h00, 3'h0);
        rel();
        check(reg_rdata, 8'hAA);
    endtask

    task automatic test_bit_ops;
        ext_val = 8'h30;
        idle(3);
        access(BPD_OP_BIT_SET, `BPD_ADDR_PORT, 8'h00, 3'h7);
        access(BPD_OP_BIT_CLEAR, `BPD_ADDR_PORT, 8'h00, 3'h1);
        access(BPD_OP_WRITE, `BPD_ADDR_DIR, 8'h00, 3'h0);
        access(BPD_OP_BIT_SET, `BPD_ADDR_DIR, 8'h00, 3'h0);
        rel();
        check(pin_out, 8'h38);
        check(pin_oe, 8'hFE);
    endtask

    task automatic test_unmapped;
        access(BPD_OP_READ, 8'h10, 8'h00, 3'h0);
        rel();
        check(reg_rdata, `BPD_UNMAPPED);
        check({7'h00, reg_miss}, 8'h01);
        access(BPD_OP_WRITE, 8'h10, 8'h00, 3'h0);
        rel();
        check({7'h00, reg_miss}, 8'h01);
        check(pin_oe, 8'hFE);
    endtask

    task automatic test_sync_delay;
        access(BPD_OP_WRITE, `BPD_ADDR_DIR, 8'hFF, 3'h0);
        rel();
        idle(3);
        ext_en = 8'hFF;
        ext_val = 8'h55;
        access(BPD_OP_READ, `BPD_ADDR_PORT, 8'h00, 3'h0);
        rel();
        check(reg_rdata, 8'h3F);
        idle(2);
        access(BPD_OP_READ, `BPD_ADDR_PORT, 8'h00, 3'h0);
        rel();
        check(reg_rdata, 8'h55);
    endtask

    task automatic test_second_reset;
        do_reset();
        check(pin_oe, 8'h00);
        access(BPD_OP_BIT_CLEAR, `BPD_ADDR_DIR, 8'h00, 3'h3);
        rel();
        check(pin_oe, 8'h08);
        check(pin_out, 8'h08);
        access(BPD_OP_WRITE, `BPD_ADDR_DIR, 8'h00, 3'h0);
        rel();
        check(pin_out, 8'h38);
    endtask

    initial begin
        @(negedge sys_clk);
        idle(1);
        reset = 1'b0;
        test_reset_state();
        test_drive_and_read();
        test_bit_ops();
        test_unmapped();
        test_sync_delay();
        test_second_reset();
        complete_run();
    end
endmodule
